// >>> common/fprg_pkg.sv
// package: constants for the fuse prom host controller
package fprg_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int WORDS  = 32;
    localparam int CLK_MHZ = 100;
    // programming times, as printed, in their own units
    localparam int SIMPLE_PULSE_MS = 50;
    localparam int SIMPLE_MAX_MS   = 1000;
    localparam int BOARD_MAX_MS    = 920;
    localparam int ACCUM_MAX_MS    = 1000;
    localparam int FAST_REST_MS    = 4000;
    localparam int VERIFY_PULSE_MS = 5;
    localparam int GROUND_MIN_US   = 1;
    localparam int GROUND_MAX_US   = 5;
    localparam int READ_US         = 10;
    // cycles per millisecond and microsecond
    localparam int CYC_PER_US = CLK_MHZ;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int PULSE_CYC  = SIMPLE_PULSE_MS * CYC_PER_MS;
    localparam int VPULSE_CYC = VERIFY_PULSE_MS * CYC_PER_MS;
    localparam int ACCUM_CYC  = ACCUM_MAX_MS * CYC_PER_MS;
    localparam int BOARD_CYC  = BOARD_MAX_MS * CYC_PER_MS;
    localparam int REST_CYC   = FAST_REST_MS * CYC_PER_MS;
    localparam int GROUND_CYC = GROUND_MIN_US * CYC_PER_US;
    localparam int READ_CYC   = READ_US * CYC_PER_US;
    localparam int CNT_W      = 32;
    // programming methods
    localparam logic [1:0] MODE_SIMPLE = 2'h0;
    localparam logic [1:0] MODE_FAST   = 2'h1;
    localparam logic [1:0] MODE_VERIFY = 2'h2;
    localparam logic [DATA_W-1:0] BLANK_WORD = 8'h00;
endpackage

// >>> verilog/fprg_img_mem.sv
// image memory: target pattern, registered read data
`timescale 1ns/1ps
module fprg_img_mem
    import fprg_pkg::*;
#(
    parameter int AW = 5,
    parameter int DW = 8
) (
    input  wire logic          CORE_CLK,  // core clock
    input  wire logic          wr_en,     // write strobe
    input  wire logic [AW-1:0] wr_addr,   // write address
    input  wire logic [DW-1:0] wr_data,   // write data
    input  wire logic [AW-1:0] rd_addr,   // read address
    output logic      [DW-1:0] rd_data    // registered read data
);
    logic [DW-1:0] mem_ff [2**AW];

    // no reset on storage: contents come from the user load port
    always_ff @(posedge CORE_CLK) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
        rd_data <= mem_ff[rd_addr];
    end
endmodule

// >>> verilog/fprg_host.sv
// host controller that reads and fuse-programs a 32x8 prom
`timescale 1ns/1ps
module fprg_host
    import fprg_pkg::*;
#(
    parameter int PULSE_CYCLES  = fprg_pkg::PULSE_CYC,
    parameter int VPULSE_CYCLES = fprg_pkg::VPULSE_CYC,
    parameter int ACCUM_CYCLES  = fprg_pkg::ACCUM_CYC,
    parameter int BOARD_CYCLES  = fprg_pkg::BOARD_CYC,
    parameter int REST_CYCLES   = fprg_pkg::REST_CYC,
    parameter int GROUND_CYCLES = fprg_pkg::GROUND_CYC,
    parameter int READ_CYCLES   = fprg_pkg::READ_CYC
) (
    input  wire logic                        CORE_CLK,       // clock
    input  wire logic                        RST_B,          // async reset
    input  wire logic                        LOAD_EN,        // image write
    input  wire logic [fprg_pkg::ADDR_W-1:0] LOAD_ADDR,      // image addr
    input  wire logic [fprg_pkg::DATA_W-1:0] LOAD_DATA,      // image data
    input  wire logic                        START,          // run pulse
    input  wire logic [1:0]                  MODE,           // method
    input  wire logic                        BOARD_LEVEL,    // wired board
    output logic                             BUSY,           // running
    output logic                             DONE,           // end pulse
    output logic                             VERIFY_FAIL,    // mismatch
    output logic [fprg_pkg::ADDR_W-1:0]      FAIL_ADDR,      // bad word
    output logic [fprg_pkg::ADDR_W-1:0]      WORD_ADDR_BIT,  // prom addr
    output logic                             SELECT_B,       // prom select
    output logic                             SUPPLY_HIGH,    // 12.5v on
    output logic                             SUPPLY_READ,    // 5v on
    output logic [fprg_pkg::DATA_W-1:0]      FUSE_DRIVE,     // bit feed
    output logic [fprg_pkg::DATA_W-1:0]      DATA_OUT_BIT_OE_B, // load en
    input  wire logic [fprg_pkg::DATA_W-1:0] DATA_OUT_BIT_I  // prom data
);
    typedef enum {
        S_IDLE, S_FETCH, S_SETUP, S_PULSE, S_GROUND, S_READ,
        S_CHECK, S_REST, S_VFETCH, S_VREAD, S_VCHECK, S_END
    } fprg_state_t;

    typedef struct packed {
        fprg_state_t        st;
        logic [1:0]         mode;
        logic               board;
        logic [ADDR_W-1:0]  addr;
        logic [2:0]         bit_idx;
        logic [CNT_W-1:0]   cnt;
        logic [CNT_W-1:0]   accum;
        logic [CNT_W-1:0]   bit_time;
        logic [DATA_W-1:0]  want;
        logic               fail;
        logic [ADDR_W-1:0]  fail_addr;
        logic               done;
        logic               verify_pass;
        logic [DATA_W-1:0]  sync1;
        logic [DATA_W-1:0]  sync2;
    } fprg_regs_t;

    fprg_regs_t   r_ff;
    fprg_regs_t   nxt_r;
    logic [DATA_W-1:0] img_data;
    logic [CNT_W-1:0]  pulse_len;
    logic [CNT_W-1:0]  pulse_cap;
    logic              want_bit;
    logic              got_bit;

    fprg_img_mem #(.AW(ADDR_W), .DW(DATA_W)) u_img (
        .CORE_CLK (CORE_CLK),
        .wr_en    (LOAD_EN & ~BUSY),
        .wr_addr  (LOAD_ADDR),
        .wr_data  (LOAD_DATA),
        .rd_addr  (r_ff.addr),
        .rd_data  (img_data)
    );

    // pulse length per method; board level trims the longest pulse
    assign pulse_cap = r_ff.board ? CNT_W'(BOARD_CYCLES)
                                  : CNT_W'(ACCUM_CYCLES);
    assign pulse_len = (r_ff.mode == MODE_VERIFY) ? CNT_W'(VPULSE_CYCLES)
                                                  : CNT_W'(PULSE_CYCLES);
    assign want_bit  = r_ff.want[r_ff.bit_idx];
    assign got_bit   = r_ff.sync2[r_ff.bit_idx];

    // next-state logic for the whole controller
    always_comb begin
        nxt_r       = r_ff;
        nxt_r.done  = 1'b0;
        // pins pass two flops before anyone looks at them
        nxt_r.sync1 = DATA_OUT_BIT_I;
        nxt_r.sync2 = r_ff.sync1;
        case (r_ff.st)
            S_IDLE: begin
                if (START) begin
                    nxt_r.mode     = MODE;
                    nxt_r.board    = BOARD_LEVEL;
                    nxt_r.addr     = '0;
                    nxt_r.accum    = '0;
                    nxt_r.fail     = 1'b0;
                    nxt_r.fail_addr = '0;
                    nxt_r.verify_pass = 1'b0;
                    nxt_r.cnt      = '0;
                    nxt_r.st       = S_FETCH;
                end
            end
            S_FETCH: begin
                // one cycle for the image read register to follow addr
                nxt_r.cnt = r_ff.cnt + 1'b1;
                if (r_ff.cnt[0]) begin
                    nxt_r.want    = img_data;
                    nxt_r.bit_idx = '0;
                    nxt_r.cnt     = '0;
                    nxt_r.st      = S_SETUP;
                end
            end
            S_SETUP: begin
                // blank bits are zero; only ones need a fuse opened
                if (want_bit) begin
                    nxt_r.cnt      = '0;
                    nxt_r.bit_time = '0;
                    nxt_r.st       = S_PULSE;
                end else if (r_ff.bit_idx == 3'(DATA_W - 1)) begin
                    nxt_r.st = S_CHECK;
                end else begin
                    nxt_r.bit_idx = r_ff.bit_idx + 1'b1;
                end
            end
            S_PULSE: begin
                nxt_r.cnt      = r_ff.cnt + 1'b1;
                nxt_r.accum    = r_ff.accum + 1'b1;
                nxt_r.bit_time = r_ff.bit_time + 1'b1;
                if (r_ff.cnt + 1'b1 >= pulse_len
                    || r_ff.bit_time + 1'b1 >= pulse_cap) begin
                    nxt_r.cnt = '0;
                    nxt_r.st  = S_GROUND;
                end
            end
            S_GROUND: begin
                // supply to ground between pulses; simple method rests
                // three pulse times once past the budget for 25% duty
                nxt_r.cnt = r_ff.cnt + 1'b1;
                if ((r_ff.mode == MODE_SIMPLE && r_ff.accum >=
                     CNT_W'(ACCUM_CYCLES)) ?
                    (r_ff.cnt + 1'b1 >= 3 * pulse_len) :
                    (r_ff.cnt + 1'b1 >= CNT_W'(GROUND_CYCLES))) begin
                    nxt_r.cnt = '0;
                    nxt_r.st  = (r_ff.mode == MODE_VERIFY) ? S_READ : S_CHECK;
                    if (r_ff.mode == MODE_FAST
                        && r_ff.accum >= CNT_W'(ACCUM_CYCLES)) begin
                        nxt_r.st = S_REST;
                    end
                end
            end
            S_READ: begin
                // lowered supply, read the bit back through the sync
                nxt_r.cnt = r_ff.cnt + 1'b1;
                if (r_ff.cnt + 1'b1 >= CNT_W'(READ_CYCLES)) begin
                    nxt_r.cnt = '0;
                    if (!got_bit && r_ff.bit_time < pulse_cap) begin
                        nxt_r.st = S_PULSE;
                    end else begin
                        nxt_r.st = (r_ff.accum >= CNT_W'(ACCUM_CYCLES))
                                   ? S_REST : S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                // next bit of this word, then next word
                if (r_ff.bit_idx != 3'(DATA_W - 1)) begin
                    nxt_r.bit_idx = r_ff.bit_idx + 1'b1;
                    nxt_r.st      = S_SETUP;
                end else if (r_ff.addr != ADDR_W'(WORDS - 1)) begin
                    nxt_r.addr = r_ff.addr + 1'b1;
                    nxt_r.st   = S_FETCH;
                end else begin
                    nxt_r.addr = '0;
                    nxt_r.st   = S_VFETCH;
                end
            end
            S_REST: begin
                // all power removed, then the budget starts afresh
                nxt_r.cnt = r_ff.cnt + 1'b1;
                if (r_ff.cnt + 1'b1 >= CNT_W'(REST_CYCLES)) begin
                    nxt_r.cnt   = '0;
                    nxt_r.accum = '0;
                    nxt_r.st    = S_CHECK;
                end
            end
            S_VFETCH: begin
                nxt_r.cnt = r_ff.cnt + 1'b1;
                if (r_ff.cnt[0]) begin
                    nxt_r.want = img_data;
                    nxt_r.cnt  = '0;
                    nxt_r.st   = S_VREAD;
                end
            end
            S_VREAD: begin
                // select low at 5v; wait for the pin to settle and sync
                nxt_r.cnt = r_ff.cnt + 1'b1;
                if (r_ff.cnt + 1'b1 >= CNT_W'(READ_CYCLES)) begin
                    nxt_r.cnt = '0;
                    nxt_r.st  = S_VCHECK;
                end
            end
            S_VCHECK: begin
                // high level is a one, compare straight to the image
                if (r_ff.sync2 != r_ff.want && !r_ff.fail) begin
                    nxt_r.fail      = 1'b1;
                    nxt_r.fail_addr = r_ff.addr;
                end
                if (r_ff.addr != ADDR_W'(WORDS - 1)) begin
                    nxt_r.addr = r_ff.addr + 1'b1;
                    nxt_r.st   = S_VFETCH;
                end else begin
                    nxt_r.st = S_END;
                end
            end
            S_END: begin
                nxt_r.done = 1'b1;
                nxt_r.st   = S_IDLE;
            end
            default: begin
                nxt_r.st = S_IDLE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            r_ff <= '{st: S_IDLE, mode: MODE_SIMPLE, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // pin drive: select low whenever the device is worked on
    assign BUSY          = (r_ff.st != S_IDLE);
    assign DONE          = r_ff.done;
    assign VERIFY_FAIL   = r_ff.fail;
    assign FAIL_ADDR     = r_ff.fail_addr;
    assign WORD_ADDR_BIT = r_ff.addr;
    assign SELECT_B      = (r_ff.st == S_IDLE);
    assign SUPPLY_HIGH   = (r_ff.st == S_PULSE);
    assign SUPPLY_READ   = (r_ff.st == S_READ || r_ff.st == S_VFETCH
                            || r_ff.st == S_VREAD || r_ff.st == S_VCHECK);
    // feed only the one bit being opened; no load otherwise
    always_comb begin
        FUSE_DRIVE        = BLANK_WORD;
        DATA_OUT_BIT_OE_B = {DATA_W{1'b1}};
        if (r_ff.st == S_PULSE) begin
            FUSE_DRIVE[r_ff.bit_idx]        = 1'b1;
            DATA_OUT_BIT_OE_B[r_ff.bit_idx] = 1'b0;
        end
    end
endmodule

// >>> dv/fprg_prom_model.sv
// behavioural 32x8 fuse prom that the host controller drives
`timescale 1ns/1ps
module fprg_prom_model
    import fprg_pkg::*;
#(
    parameter int NEED = 8  // pulse cycles a fuse needs before it opens
) (
    input  wire logic                        clk,    // times the pulses
    input  wire logic [fprg_pkg::ADDR_W-1:0] addr,   // word select lines
    input  wire logic                        sel_b,  // active-low select
    input  wire logic                        sup_hi, // programming supply
    input  wire logic [fprg_pkg::DATA_W-1:0] feed,   // output being fed
    output logic      [fprg_pkg::DATA_W-1:0] q_pull  // 1 pulls line low
);
    logic [DATA_W-1:0] mem [WORDS];
    int                hot;
    logic [DATA_W-1:0] last_f;
    logic [ADDR_W-1:0] last_a;

    // a blank part has every fuse intact, so every bit reads zero
    initial begin
        foreach (mem[i]) mem[i] = BLANK_WORD;
        hot = 0;
        last_f = '0;
        last_a = '0;
    end

    // heat adds up over retries of one bit; a slow fuse needs a retry
    always @(posedge clk) begin
        if (sup_hi && !sel_b && $onehot(feed)) begin
            hot = (feed == last_f && addr == last_a) ? hot + 1 : 1;
            last_f = feed;
            last_a = addr;
            if (hot >= NEED) mem[addr] = mem[addr] | feed;
        end
    end

    // open collector: intact fuse sinks, released line floats high
    assign q_pull = sel_b ? 8'h00 : ~mem[addr];
endmodule

// >>> dv/fprg_host_asserts.sv
// checker: port-level programming discipline of the host controller
`timescale 1ns/1ps
module fprg_host_asserts
    import fprg_pkg::*;
#(
    parameter int PULSE_CYCLES  = 20,
    parameter int VPULSE_CYCLES = 5
) (
    input wire logic                        CORE_CLK,          // clock
    input wire logic                        RST_B,             // reset
    input wire logic                        START,             // run pulse
    input wire logic [1:0]                  MODE,              // method
    input wire logic                        BUSY,              // running
    input wire logic                        DONE,              // end pulse
    input wire logic                        VERIFY_FAIL,       // mismatch
    input wire logic [fprg_pkg::ADDR_W-1:0] WORD_ADDR_BIT,     // prom addr
    input wire logic                        SELECT_B,          // select
    input wire logic                        SUPPLY_HIGH,       // 12.5v
    input wire logic                        SUPPLY_READ,       // 5v
    input wire logic [fprg_pkg::DATA_W-1:0] FUSE_DRIVE,        // fed bit
    input wire logic [fprg_pkg::DATA_W-1:0] DATA_OUT_BIT_OE_B  // drive en
);
    logic [31:0] hi_cnt;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);

    // cycles the supply has been high; a stuck pulse would burn the part
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hi_cnt <= '0;
        end else begin
            hi_cnt <= SUPPLY_HIGH ? hi_cnt + 32'h0000_0001 : '0;
        end
    end

    AST_SEL_BUSY: assert property (SELECT_B != BUSY)
        else $error("select does not follow busy");
    AST_START: assert property (START && !BUSY |=> BUSY && !SELECT_B)
        else $error("start in idle not taken");
    AST_ONE_BIT: assert property (SUPPLY_HIGH |-> $onehot(FUSE_DRIVE))
        else $error("pulse feeds other than one bit");
    AST_UNLOAD: assert property (SUPPLY_HIGH |-> !SELECT_B &&
        DATA_OUT_BIT_OE_B == ~FUSE_DRIVE)
        else $error("outputs loaded during pulse");
    AST_QUIET: assert property (!SUPPLY_HIGH |->
        DATA_OUT_BIT_OE_B == 8'hff && FUSE_DRIVE == 8'h00)
        else $error("output driven outside a pulse");
    AST_HOLD: assert property (SUPPLY_HIGH && $past(SUPPLY_HIGH) |->
        $stable(WORD_ADDR_BIT) && $stable(FUSE_DRIVE))
        else $error("address or bit moved in a pulse");
    AST_CAP: assert property (SUPPLY_HIGH |-> hi_cnt < PULSE_CYCLES)
        else $error("pulse too long");
    AST_WIDTH: assert property ($fell(SUPPLY_HIGH) &&
        MODE == MODE_SIMPLE |-> hi_cnt == PULSE_CYCLES)
        else $error("simple pulse width wrong");
    AST_NO_OVERLAP: assert property (!(SUPPLY_HIGH && SUPPLY_READ))
        else $error("both supplies on");
    AST_VREAD: assert property ($fell(SUPPLY_HIGH) &&
        MODE == MODE_VERIFY |-> hi_cnt == VPULSE_CYCLES ##[1:3] SUPPLY_READ)
        else $error("verify pulse not followed by read");
    AST_DONE: assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");

    // main scenarios reached
    cover property ($fell(SUPPLY_HIGH) && MODE == MODE_VERIFY);
    cover property (DONE && VERIFY_FAIL);
    cover property (START && BUSY);
endmodule

bind fprg_host fprg_host_asserts #(
    .PULSE_CYCLES (PULSE_CYCLES),
    .VPULSE_CYCLES(VPULSE_CYCLES)
) i_asserts (
    .CORE_CLK, .RST_B, .START, .MODE, .BUSY, .DONE, .VERIFY_FAIL,
    .WORD_ADDR_BIT, .SELECT_B, .SUPPLY_HIGH, .SUPPLY_READ, .FUSE_DRIVE,
    .DATA_OUT_BIT_OE_B
);

// >>> dv/testbench.sv
// self-checking bench: host controller against the fuse prom model
`timescale 1ns/1ps
module testbench;
    import fprg_pkg::*;
    logic              clk = 0, rst_b = 0, ld_en = 0, start = 0, board = 0;
    logic [1:0]        mode = 0;
    logic [ADDR_W-1:0] ld_a = 0, fail_a, wa;
    logic [DATA_W-1:0] ld_d = 0, feed, oe_b, d_i, pull;
    logic              busy, done, vfail, sel_b, s_hi, s_rd;
    logic [DATA_W-1:0] img [WORDS];
    int                fails = 0, compares = 0;

    // shortened counts keep the run brief; pulse timing scales with them
    localparam int T_PULSE  = 20;   // stands for the 50 ms pulse
    localparam int T_VPULSE = 5;    // stands for the 5 ms verify pulse
    localparam int T_ACCUM  = 200;  // stands for one second of supply
    localparam int T_BOARD  = 184;  // 0.92 of that budget
    localparam int T_REST   = 50;   // rest with power removed
    localparam int T_GROUND = 1;    // grounded gap between pulses
    localparam int T_READ   = 4;    // lowered supply read window

    always #5 clk = ~clk;

    fprg_host #(.PULSE_CYCLES(T_PULSE), .VPULSE_CYCLES(T_VPULSE),
        .ACCUM_CYCLES(T_ACCUM), .BOARD_CYCLES(T_BOARD),
        .REST_CYCLES(T_REST), .GROUND_CYCLES(T_GROUND),
        .READ_CYCLES(T_READ)) i_dut (
        .CORE_CLK(clk), .RST_B(rst_b), .LOAD_EN(ld_en), .LOAD_ADDR(ld_a),
        .LOAD_DATA(ld_d), .START(start), .MODE(mode), .BOARD_LEVEL(board),
        .BUSY(busy), .DONE(done), .VERIFY_FAIL(vfail), .FAIL_ADDR(fail_a),
        .WORD_ADDR_BIT(wa), .SELECT_B(sel_b), .SUPPLY_HIGH(s_hi),
        .SUPPLY_READ(s_rd), .FUSE_DRIVE(feed), .DATA_OUT_BIT_OE_B(oe_b),
        .DATA_OUT_BIT_I(d_i));
    fprg_prom_model i_prom (.clk(clk), .addr(wa), .sel_b(sel_b),
        .sup_hi(s_hi), .feed(feed), .q_pull(pull));

    // wired-AND line with pull-up; host drive wins only where enabled
    assign d_i = ~pull | ~oe_b;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic chk_idle();
        @(negedge clk);
        chk({busy, sel_b, s_hi, s_rd, done}, 5'h08);
        chk(oe_b, 8'hff);
        chk(feed, 8'h00);
        chk(d_i, 8'hff);
    endtask

    task automatic chk_mem();
        for (int i = 0; i < WORDS; i++) chk(i_prom.mem[i], img[i]);
    endtask

    // poke tries a load and a start mid-run; both must be ignored
    task automatic run(input logic [1:0] m, input logic b, efail, poke);
        int n;
        for (int i = 0; i < WORDS; i++) begin
            @(posedge clk);
            ld_en <= 1'b1;
            ld_a  <= i[ADDR_W-1:0];
            ld_d  <= img[i];
        end
        @(posedge clk);
        ld_en <= 1'b0;
        start <= 1'b1;
        mode  <= m;
        board <= b;
        @(posedge clk);
        start <= 1'b0;
        if (poke) begin
            repeat (60) @(posedge clk);
            ld_en <= 1'b1;
            ld_a  <= '0;
            ld_d  <= 8'hff;
            start <= 1'b1;
            @(posedge clk);
            ld_en <= 1'b0;
            start <= 1'b0;
        end
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk(n < 20000, 1);
        @(negedge clk);
        chk(vfail, efail);
    endtask

    // twelve bits pass the supply budget, so later grounds stretch
    task automatic t_simple();
        img[0] = 8'h01;
        img[3] = 8'h81;
        img[20] = 8'hff;
        img[31] = 8'h80;
        run(MODE_SIMPLE, 1'b0, 1'b0, 1'b0);
        chk_mem();
        $display("simple method done");
    endtask

    // an opened fuse cannot be closed, so readback must flag word 3
    task automatic t_fail();
        img[3] = 8'h01;
        run(2'h3, 1'b0, 1'b1, 1'b0);
        chk(fail_a, 32'h0000_0003);
        chk(i_prom.mem[3], 8'h81);
        img[3] = 8'h81;
        $display("irreversible fuse done");
    endtask

    task automatic t_verify();
        img[5] = 8'h24;
        run(MODE_VERIFY, 1'b0, 1'b0, 1'b0);
        chk_mem();
        $display("verify loop done");
    endtask

    // the accumulated limit is passed twice and forces two rests
    task automatic t_fast();
        img[10] = 8'hff;
        img[11] = 8'h07;
        run(MODE_FAST, 1'b1, 1'b0, 1'b1);
        chk_mem();
        $display("fast method done");
    endtask

    task automatic t_abort();
        @(posedge clk);
        start <= 1'b1;
        mode  <= MODE_FAST;
        @(posedge clk);
        start <= 1'b0;
        repeat (40) @(posedge clk);
        rst_b <= 1'b0;
        chk_idle();
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk_idle();
        $display("abort by reset done");
    endtask

    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        foreach (img[i]) img[i] = BLANK_WORD;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk_idle();
        t_simple();
        t_fail();
        t_verify();
        t_fast();
        t_abort();
        give_verdict();
    end

    // runs take a few thousand cycles; 40000 means a hang
    initial begin
        #400_000;
        fails++;
        give_verdict();
    end
endmodule
